/* diag_monitor_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef DIAG_MONITOR_MAP_SVH
`define DIAG_MONITOR_MAP_SVH

`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES_DFLT (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define HOUR_TICKS_DFLT 3600000
`define DISP_TICKS 1000

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CMD 8'h08
`define ADDR_SAT_RESP 8'h0C
`define ADDR_SAT_STOP 8'h10
`define ADDR_TMR_LIM 8'h14
`define ADDR_TMR_DIFF 8'h18
`define ADDR_TMR_STEP 8'h08
`define ADDR_TMR_CNT 8'h24
`define ADDR_CNT_STEP 8'h04
`define ADDR_HOURS_ELEC 8'h2C
`define ADDR_HOURS_SENS 8'h30
`define ADDR_PEAK_MIN 8'h34
`define ADDR_PEAK_MAX 8'h38
`define ADDR_PEAK_STEP 8'h08

`define CTRL_COMMISSION 0
`define CTRL_SAT_EN 1
`define CTRL_SAT_INT 2
`define CTRL_TMR_EN 3
`define CTRL_DIR_LO 5
`define CTRL_ACTIVE_UP 7
`define CTRL_RESET 8'h00

`define CMD_TMR_ACK 0
`define CMD_TMR_RST 1
`define CMD_PEAK_RST 4

`define STAT_WARN 0
`define STAT_FAULT 1
`define STAT_FAULT_UP 2
`define STAT_SAT_RESP 3
`define STAT_SAT_HOLD 4
`define STAT_TMR_REQ 5
`define STAT_TMR_ALARM 7
`define STAT_COMMISSIONED 9

`endif

/* diag_monitor_pkg.sv */
// Types shared by the diagnostic monitor
package diag_monitor_pkg;

	typedef enum logic [1:0] {
		DIR_ACTIVE,
		DIR_INVERSE,
		DIR_SATURATED,
		DIR_OPPOSITE
	} fault_dir_t;

	typedef enum logic [1:0] {
		SAT_IDLE,
		SAT_RESPOND,
		SAT_HOLD
	} sat_state_t;

	typedef struct packed {
		logic signed [2:0][15:0] value;
	} meas_t;

	typedef struct packed {
		logic commissioned;
		logic [31:0] hours_elec;
		logic [31:0] hours_sens;
		logic signed [2:0][15:0] peak_min;
		logic signed [2:0][15:0] peak_max;
	} nv_image_t;

endpackage : diag_monitor_pkg

/* diag_monitor.sv */
// Diagnostic supervisor: hours counters, two-stage timers, peaks, saturation
//
// Operation
// - Warning reported to host, current unchanged
// - Warning alternates display between text and unit
// - Interrupt forces fault current and reports event
// - All diagnostic sources disabled after default
// - Saturation source: warning only or interrupt too
// - Electronics and sensor hours counters, host readable
// - Hours start at commissioning, saved and restored
// - No way to clear hours counters
// - Timer first period raises request
// - Difference interval later: alarm and fault current
// - Host can deactivate timer monitoring
// - Reset before limit restarts timer from zero
// - Acknowledge before limit has no effect
// - Acknowledge after limit clears, no further report
// - Reset after limit clears and restarts timer
// - Min and max peaks for three variables
// - Peaks resettable by host, kept nonvolatile
// - Peaks follow substituted values during simulation
// - Saturation interrupt only after full response time
// - Short saturation never reaches fault current
// - Interrupt held until sat_stop ticks of the time base are counted, then revoked
// - Four selectable saturation fault directions
`timescale 1ns/1ns
`include "diag_monitor_map.svh"

module diag_monitor
	import diag_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES_DFLT,
	parameter int HOUR_TICKS = `HOUR_TICKS_DFLT,
	parameter int NUM_TMR = 2,
	parameter int NUM_VAR = 3
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [7:0] addr, // Register byte address
	input wire logic [31:0] wdata, // Register write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after rd
	input wire meas_t meas, // Live measured values
	input wire meas_t sim_meas, // Substituted simulation values
	input wire logic [2:0] sim_active, // Simulation active per variable
	input wire logic sat_hi, // Output current at upper saturation
	input wire logic sat_lo, // Output current at lower saturation
	input wire logic pwr_fail, // Supply loss warning, level
	input wire logic nv_load, // Restore pulse with nv_in
	input wire nv_image_t nv_in, // Image read back from storage
	output nv_image_t nv_out, // Image to store
	output logic nv_save, // Store pulse on supply loss
	output logic diag_warning, // Warning active, reported to host
	output logic fault_current, // Force fault current
	output logic fault_up, // Fault current direction upward
	output logic disp_alt, // Display shows warning text when high
	output logic disp_error // Display shows error mark
);

	logic [31:0] ctrl;
	logic [31:0] sat_resp;
	logic [31:0] sat_stop;
	logic [31:0] tmr_lim [NUM_TMR];
	logic [31:0] tmr_diff [NUM_TMR];
	logic [31:0] tmr_cnt [NUM_TMR];
	logic tmr_done [NUM_TMR];
	logic [NUM_TMR-1:0] tmr_req;
	logic [NUM_TMR-1:0] tmr_alarm;
	logic [31:0] tick_cnt;
	logic tick;
	logic [31:0] hour_pre, hours_elec, hours_sens;
	logic [31:0] disp_cnt;
	logic pwr_fail_q;
	sat_state_t sat_state;
	logic [31:0] sat_cnt;
	logic sat_dir_up;
	logic sat_fault;
	logic sat_warn;
	logic cmd_wr;
	logic signed [15:0] cur [NUM_VAR];
	logic [31:0] next_rdata;
	logic signed [15:0] peak_min [NUM_VAR], peak_max [NUM_VAR];

	assign cmd_wr = wr && addr == `ADDR_CMD;

	// Register writes; defaults keep every source off
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= {24'h0000_00, `CTRL_RESET};
			sat_resp <= 32'h0000_0000;
			sat_stop <= 32'h0000_0000;
		end else begin
			if (wr && addr == `ADDR_CTRL) begin
				// Commission bit is sticky once set
				ctrl <= {24'h0000_00, wdata[7:1], ctrl[`CTRL_COMMISSION] | wdata[0]};
			end else if (nv_load && nv_in.commissioned) begin
				ctrl[`CTRL_COMMISSION] <= 1'b1;
			end
			if (wr && addr == `ADDR_SAT_RESP) begin
				sat_resp <= wdata;
			end
			if (wr && addr == `ADDR_SAT_STOP) begin
				sat_stop <= wdata;
			end
		end
	end

	// Common time base
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == 32'(TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 32'd1;
		end
	end

	// Hours counters; the host never writes them, only reset, a restore or the hour count changes them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hour_pre <= 32'h0000_0000;
			hours_elec <= 32'h0000_0000;
			hours_sens <= 32'h0000_0000;
		end else if (nv_load) begin
			hours_elec <= nv_in.hours_elec;
			hours_sens <= nv_in.hours_sens;
		end else if (tick && ctrl[`CTRL_COMMISSION]) begin
			if (hour_pre == 32'(HOUR_TICKS - 1)) begin
				hour_pre <= 32'h0000_0000;
				hours_elec <= hours_elec + 32'd1;
				hours_sens <= hours_sens + 32'd1;
			end else begin
				hour_pre <= hour_pre + 32'd1;
			end
		end
	end

	assign nv_out = {ctrl[`CTRL_COMMISSION], hours_elec, hours_sens,
		peak_min[2], peak_min[1], peak_min[0], peak_max[2], peak_max[1], peak_max[0]};

	// Store request on falling supply
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwr_fail_q <= 1'b0;
			nv_save <= 1'b0;
		end else begin
			pwr_fail_q <= pwr_fail;
			nv_save <= pwr_fail && !pwr_fail_q;
		end
	end

	// Calibration and service timers
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
			logic ack;
			logic rst;
			logic reached1;
			logic reached2;
			logic [32:0] lim2;
			assign ack = cmd_wr && wdata[`CMD_TMR_ACK + 2 * gi];
			assign rst = cmd_wr && wdata[`CMD_TMR_RST + 2 * gi];
			assign lim2 = {1'b0, tmr_lim[gi]} + {1'b0, tmr_diff[gi]};
			assign reached1 = tmr_cnt[gi] >= tmr_lim[gi];
			assign reached2 = {1'b0, tmr_cnt[gi]} >= lim2;
			assign tmr_req[gi] = ctrl[`CTRL_TMR_EN + gi] && reached1 && !tmr_done[gi];
			assign tmr_alarm[gi] = ctrl[`CTRL_TMR_EN + gi] && reached2 && !tmr_done[gi];

			always_ff @(posedge clk) begin
				if (!nrst) begin
					tmr_lim[gi] <= 32'h0000_0000;
					tmr_diff[gi] <= 32'h0000_0000;
				end else begin
					if (wr && addr == 8'(`ADDR_TMR_LIM + `ADDR_TMR_STEP * gi)) begin
						tmr_lim[gi] <= wdata;
					end
					if (wr && addr == 8'(`ADDR_TMR_DIFF + `ADDR_TMR_STEP * gi)) begin
						tmr_diff[gi] <= wdata;
					end
				end
			end

			always_ff @(posedge clk) begin
				if (!nrst) begin
					tmr_cnt[gi] <= 32'h0000_0000;
					tmr_done[gi] <= 1'b0;
				end else if (!ctrl[`CTRL_TMR_EN + gi]) begin
					tmr_cnt[gi] <= 32'h0000_0000;
					tmr_done[gi] <= 1'b0;
				end else if (rst) begin
					tmr_cnt[gi] <= 32'h0000_0000;
					tmr_done[gi] <= 1'b0;
				end else begin
					if (ack && reached1) begin
						tmr_done[gi] <= 1'b1;
					end
					if (tick && tmr_cnt[gi] != 32'hFFFF_FFFF) begin
						tmr_cnt[gi] <= tmr_cnt[gi] + 32'd1;
					end
				end
			end
		end
	endgenerate

	// Peak trackers
	generate
		for (gi = 0; gi < NUM_VAR; gi++) begin : g_peak
			logic prst;
			assign prst = cmd_wr && wdata[`CMD_PEAK_RST + gi];
			assign cur[gi] = sim_active[gi] ? sim_meas.value[gi] : meas.value[gi];

			always_ff @(posedge clk) begin
				if (!nrst) begin
					peak_min[gi] <= 16'h7FFF;
					peak_max[gi] <= 16'h8000;
				end else if (nv_load) begin
					peak_min[gi] <= nv_in.peak_min[gi];
					peak_max[gi] <= nv_in.peak_max[gi];
				end else if (prst) begin
					peak_min[gi] <= cur[gi];
					peak_max[gi] <= cur[gi];
				end else begin
					if (cur[gi] < peak_min[gi]) begin
						peak_min[gi] <= cur[gi];
					end
					if (cur[gi] > peak_max[gi]) begin
						peak_max[gi] <= cur[gi];
					end
				end
			end
		end
	endgenerate

	// Saturation monitor
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sat_state <= SAT_IDLE;
			sat_cnt <= 32'h0000_0000;
			sat_dir_up <= 1'b0;
		end else begin
			case (sat_state)
				SAT_IDLE: begin
					sat_cnt <= 32'h0000_0000;
					if (ctrl[`CTRL_SAT_EN] && (sat_hi || sat_lo)) begin
						sat_state <= SAT_RESPOND;
					end
				end
				SAT_RESPOND: begin
					if (!ctrl[`CTRL_SAT_EN] || !(sat_hi || sat_lo)) begin
						sat_state <= SAT_IDLE;
					end else if (sat_cnt >= sat_resp) begin
						sat_state <= SAT_HOLD;
						sat_cnt <= 32'h0000_0000;
						sat_dir_up <= sat_hi;
					end else if (tick) begin
						sat_cnt <= sat_cnt + 32'd1;
					end
				end
				SAT_HOLD: begin
					if (!ctrl[`CTRL_SAT_EN] || sat_cnt >= sat_stop) begin
						sat_state <= SAT_IDLE;
					end else if (tick) begin
						sat_cnt <= sat_cnt + 32'd1;
					end
				end
				default: begin
					sat_state <= SAT_IDLE;
				end
			endcase
		end
	end

	assign sat_warn = sat_state == SAT_HOLD;
	assign sat_fault = sat_warn && ctrl[`CTRL_SAT_INT];

	// Fault and warning outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			diag_warning <= 1'b0;
			fault_current <= 1'b0;
			fault_up <= 1'b0;
		end else begin
			diag_warning <= sat_warn || (|tmr_req);
			fault_current <= sat_fault || (|tmr_alarm);
			if (sat_fault) begin
				case (fault_dir_t'(ctrl[`CTRL_DIR_LO +: 2]))
					DIR_ACTIVE: fault_up <= ctrl[`CTRL_ACTIVE_UP];
					DIR_INVERSE: fault_up <= !ctrl[`CTRL_ACTIVE_UP];
					DIR_SATURATED: fault_up <= sat_dir_up;
					DIR_OPPOSITE: fault_up <= !sat_dir_up;
					default: fault_up <= ctrl[`CTRL_ACTIVE_UP];
				endcase
			end else begin
				fault_up <= ctrl[`CTRL_ACTIVE_UP];
			end
		end
	end

	// Display alternation while warning stands
	always_ff @(posedge clk) begin
		if (!nrst) begin
			disp_cnt <= 32'h0000_0000;
			disp_alt <= 1'b0;
			disp_error <= 1'b0;
		end else begin
			disp_error <= fault_current;
			if (!diag_warning) begin
				disp_cnt <= 32'h0000_0000;
				disp_alt <= 1'b0;
			end else if (tick) begin
				if (disp_cnt == 32'(`DISP_TICKS - 1)) begin
					disp_cnt <= 32'h0000_0000;
					disp_alt <= !disp_alt;
				end else begin
					disp_cnt <= disp_cnt + 32'd1;
				end
			end
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (addr)
			`ADDR_CTRL: next_rdata = ctrl;
			`ADDR_STATUS: begin
				next_rdata[`STAT_WARN] = diag_warning;
				next_rdata[`STAT_FAULT] = fault_current;
				next_rdata[`STAT_FAULT_UP] = fault_up;
				next_rdata[`STAT_SAT_RESP] = sat_state == SAT_RESPOND;
				next_rdata[`STAT_SAT_HOLD] = sat_warn;
				next_rdata[`STAT_TMR_REQ +: 2] = tmr_req;
				next_rdata[`STAT_TMR_ALARM +: 2] = tmr_alarm;
				next_rdata[`STAT_COMMISSIONED] = ctrl[`CTRL_COMMISSION];
			end
			`ADDR_SAT_RESP: next_rdata = sat_resp;
			`ADDR_SAT_STOP: next_rdata = sat_stop;
			`ADDR_HOURS_ELEC: next_rdata = nv_out.hours_elec;
			`ADDR_HOURS_SENS: next_rdata = nv_out.hours_sens;
			default: next_rdata = 32'h0000_0000;
		endcase
		for (int i = 0; i < NUM_TMR; i++) begin
			if (addr == 8'(`ADDR_TMR_LIM + `ADDR_TMR_STEP * i)) next_rdata = tmr_lim[i];
			if (addr == 8'(`ADDR_TMR_DIFF + `ADDR_TMR_STEP * i)) next_rdata = tmr_diff[i];
			if (addr == 8'(`ADDR_TMR_CNT + `ADDR_CNT_STEP * i)) next_rdata = tmr_cnt[i];
		end
		for (int i = 0; i < NUM_VAR; i++) begin
			if (addr == 8'(`ADDR_PEAK_MIN + `ADDR_PEAK_STEP * i)) begin
				next_rdata = {{16{nv_out.peak_min[i][15]}}, nv_out.peak_min[i]};
			end
			if (addr == 8'(`ADDR_PEAK_MAX + `ADDR_PEAK_STEP * i)) begin
				next_rdata = {{16{nv_out.peak_max[i][15]}}, nv_out.peak_max[i]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? next_rdata : 32'h0000_0000;
		end
	end

endmodule : diag_monitor

/* diag_monitor_asserts.sv */
// Port-level checks on the diagnostic monitor
`timescale 1ns/1ns
module diag_monitor_asserts (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic rd, // Read strobe
	input wire logic [31:0] rdata, // Read data
	input wire logic pwr_fail, // Supply loss
	input wire logic nv_save, // Store pulse
	input wire logic diag_warning, // Warning level
	input wire logic fault_current, // Fault current
	input wire logic fault_up, // Fault direction
	input wire logic disp_alt, // Display alternates
	input wire logic disp_error // Display error mark
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read cycle");
	err_follow_a: assert property (1'b1 |-> disp_error == $past(fault_current))
		else $error("error mark not following fault");
	save_pulse_a: assert property ($rose(pwr_fail) |-> ##[1:2] nv_save)
		else $error("no store on supply loss");
	save_single_a: assert property (nv_save |=> !nv_save)
		else $error("store pulse too long");
	save_cause_a: assert property (nv_save |-> $past(pwr_fail) || $past(pwr_fail, 2))
		else $error("store without supply loss");
	alt_quiet_a: assert property (!diag_warning [*2] |-> !disp_alt)
		else $error("display alternates without warning");
	alt_steady_a: assert property ($changed(disp_alt) && diag_warning ##1 diag_warning
		|-> $stable(disp_alt))
		else $error("display alternates too fast");
	dir_steady_a: assert property (fault_current && $past(fault_current) |-> $stable(fault_up))
		else $error("fault direction moved during fault");
endmodule : diag_monitor_asserts

bind diag_monitor diag_monitor_asserts chk_u (.clk(clk), .nrst(nrst), .rd(rd), .rdata(rdata),
	.pwr_fail(pwr_fail), .nv_save(nv_save), .diag_warning(diag_warning),
	.fault_current(fault_current), .fault_up(fault_up), .disp_alt(disp_alt),
	.disp_error(disp_error));

/* host_model.sv */
// Remote host model driving the register port
`timescale 1ns/1ns
module host_model (
	input wire logic clk, // Clock
	output logic [7:0] addr, // Register address
	output logic [31:0] wdata, // Write data
	output logic wr, // Write strobe
	output logic rd, // Read strobe
	input wire logic [31:0] rdata // Read data
);
	initial begin
		addr = 8'hFF;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Idle cycle after each access keeps strobes single-driven per step
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
		@(posedge clk);
	endtask : put
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		d = rdata;
	endtask : get
endmodule : host_model

/* transmitter_diagnostic_monitor_test.sv */
// Self-checking testbench of the diagnostic monitor
`timescale 1ns/1ns
module transmitter_diagnostic_monitor_test;
	import diag_monitor_pkg::*;
	logic clk, nrst, wr, rd, sat_hi, sat_lo, pwr_fail, nv_load, nv_save;
	logic diag_warning, fault_current, fault_up, disp_alt, disp_error;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d, h;
	logic [2:0] sim_active;
	meas_t meas, sim_meas;
	nv_image_t nv_in, nv_out;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	diag_monitor #(.TICK_CYCLES(4), .HOUR_TICKS(3)) dut_u (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .sim_meas(sim_meas),
		.sim_active(sim_active), .sat_hi(sat_hi), .sat_lo(sat_lo), .pwr_fail(pwr_fail),
		.nv_load(nv_load), .nv_in(nv_in), .nv_out(nv_out), .nv_save(nv_save),
		.diag_warning(diag_warning), .fault_current(fault_current), .fault_up(fault_up),
		.disp_alt(disp_alt), .disp_error(disp_error));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		if (fail_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wait_for(ref logic sig, input logic lvl, input int lim);
		n = 0;
		while (sig !== lvl) begin
			@(posedge clk);
			n++;
			if (n > lim) begin
				$display("[ERR] wait expected %b seen %b", lvl, sig);
				fail_count++;
				finish_test();
			end
		end
	endtask : wait_for
	task automatic test_hours();
		host_u.get(8'h00, d);
		check("ctrl default", d, 32'h0);
		host_u.get(8'h2C, d);
		check("hours idle", d, 32'h0);
		host_u.put(8'h00, 32'h1);
		host_u.put(8'h00, 32'h0);
		host_u.get(8'h00, d);
		check("commissioned", d & 32'h1, 32'h1);
		repeat (120) @(posedge clk);
		host_u.get(8'h2C, d);
		check("hours elec", 32'(d >= 32'h9 && d <= 32'hC), 32'h1);
		host_u.get(8'h30, d);
		check("hours sens", 32'(d >= 32'h9 && d <= 32'hC), 32'h1);
		host_u.put(8'h08, 32'h7F);
		host_u.put(8'h2C, 32'h0);
		host_u.get(8'h2C, h);
		check("hours kept", 32'(h >= d), 32'h1);
		pwr_fail <= 1'b1;
		repeat (3) @(posedge clk);
		check("nv hours", 32'(nv_out.hours_elec >= h), 32'h1);
		pwr_fail <= 1'b0;
		nv_in.hours_elec <= 32'h0001_0000;
		nv_in.commissioned <= 1'b1;
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		host_u.get(8'h2C, d);
		check("hours restored", 32'(d >= 32'h0001_0000 && d <= 32'h0001_0002), 32'h1);
	endtask : test_hours
	task automatic test_timer();
		host_u.put(8'h14, 32'h3);
		host_u.put(8'h18, 32'h0000_04B0);
		host_u.put(8'h00, 32'h9);
		repeat (6) @(posedge clk);
		host_u.put(8'h08, 32'h2);
		host_u.get(8'h24, d);
		check("reset early", 32'(d <= 32'h1), 32'h1);
		host_u.put(8'h08, 32'h1);
		wait_for(diag_warning, 1'b1, 30);
		check("request only", fault_current, 32'h0);
		wait_for(disp_alt, 1'b1, 4500);
		check("warn current", fault_current, 32'h0);
		wait_for(fault_current, 1'b1, 1000);
		host_u.get(8'h04, d);
		check("status alarm", d, 32'h0000_02A3);
		host_u.put(8'h08, 32'h1);
		repeat (3) @(posedge clk);
		check("ack fault", fault_current, 32'h0);
		check("ack warn", diag_warning, 32'h0);
		host_u.get(8'h24, h);
		repeat (40) @(posedge clk);
		check("no rereport", diag_warning, 32'h0);
		host_u.get(8'h24, d);
		check("still runs", 32'(d > h), 32'h1);
		host_u.put(8'h08, 32'h2);
		check("reset clears", diag_warning, 32'h0);
		wait_for(diag_warning, 1'b1, 30);
		host_u.put(8'h00, 32'h1);
		repeat (2) @(posedge clk);
		check("disabled", diag_warning, 32'h0);
		host_u.put(8'h1C, 32'h2);
		host_u.put(8'h20, 32'h0000_0100);
		host_u.put(8'h00, 32'h11);
		wait_for(diag_warning, 1'b1, 30);
		host_u.get(8'h04, d);
		check("status req1", d, 32'h0000_0241);
		host_u.put(8'h08, 32'h8);
		host_u.get(8'h28, d);
		check("reset t1", 32'(d <= 32'h1), 32'h1);
		host_u.put(8'h00, 32'h1);
	endtask : test_timer
	task automatic test_sat();
		host_u.put(8'h0C, 32'h3);
		host_u.put(8'h10, 32'h4);
		for (int m = 0; m < 4; m++) begin
			host_u.put(8'h00, 32'h87 | 32'(m << 5));
			sat_hi <= 1'b1;
			repeat (6) @(posedge clk);
			sat_hi <= 1'b0;
			repeat (20) @(posedge clk);
			check("short sat", fault_current, 32'h0);
			sat_lo <= 1'b1;
			wait_for(fault_current, 1'b1, 40);
			check("response", 32'(n >= 10), 32'h1);
			sat_lo <= 1'b0;
			check("direction", fault_up, 32'((4'b1001 >> m) & 4'h1));
			wait_for(fault_current, 1'b0, 40);
			check("stop time", 32'(n >= 12 && n <= 20), 32'h1);
		end
		host_u.put(8'h00, 32'h3);
		sat_hi <= 1'b1;
		wait_for(diag_warning, 1'b1, 40);
		check("warn only", fault_current, 32'h0);
		sat_hi <= 1'b0;
		wait_for(diag_warning, 1'b0, 40);
	endtask : test_sat
	task automatic test_peaks();
		meas.value[0] <= 16'h0064;
		@(posedge clk);
		host_u.put(8'h08, 32'h10);
		meas.value[0] <= 16'h012C;
		repeat (2) @(posedge clk);
		meas.value[0] <= 16'hFFCE;
		repeat (2) @(posedge clk);
		meas.value[0] <= 16'h0064;
		host_u.get(8'h34, d);
		check("min", d, 32'hFFFF_FFCE);
		host_u.get(8'h38, d);
		check("max", d, 32'h0000_012C);
		host_u.put(8'h08, 32'h20);
		sim_meas.value[1] <= 16'h01F4;
		sim_active <= 3'b010;
		repeat (2) @(posedge clk);
		sim_active <= 3'b000;
		host_u.get(8'h40, d);
		check("sim max", d, 32'h0000_01F4);
		host_u.put(8'h08, 32'h10);
		host_u.get(8'h34, d);
		check("reset min", d, 32'h0000_0064);
		host_u.get(8'h38, d);
		check("reset max", d, 32'h0000_0064);
		nv_in.peak_max[2] <= 16'h0123;
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		host_u.get(8'h48, d);
		check("peak restored", d, 32'h0000_0123);
	endtask : test_peaks
	initial begin
		nrst = 1'b0;
		{sat_hi, sat_lo, pwr_fail, nv_load, sim_active} = '0;
		meas = '0;
		sim_meas = '0;
		nv_in = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		test_hours();
		test_timer();
		test_sat();
		test_peaks();
		finish_test();
	end
endmodule : transmitter_diagnostic_monitor_test
